// ### hw/stm_slave.sv
// Serial bus slave front end of the temperature monitor
`timescale 1ns/10ps
`default_nettype none

module stm_slave #(
  parameter int CONV_CYCLES = stm_pkg::CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Measurement inputs from the converters
  input  wire logic [7:0] local_temp,
  input  wire logic [7:0] remote_sample,
  // Register contents presented to the rest of the chip
  output logic [7:0]      config_reg,
  output logic [7:0]      scratch_reg,
  output logic [7:0]      remote_temp,
  output logic            busy
);

  stm_pkg::stm_state_type  state_reg;
  stm_pkg::stm_bus_ev_type ev;
  stm_pkg::stm_wr_type     wr;

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [1:0] wbyte_reg;
  logic       dir_rd_reg;
  logic       addr_hit_reg;
  logic [7:0] ptr_reg;
  logic [7:0] local_reg;
  logic       drive_low_reg;
  logic [7:0] tx_reg;
  logic       result_new;
  logic [7:0] rd_byte;

  // Read multiplexer over the pointer-selected registers
  function automatic logic [7:0] read_sel(input logic [7:0] idx, input logic [7:0] cfg,
                                          input logic [7:0] scr, input logic [7:0] loc,
                                          input logic [7:0] rem);
    case (idx)
      stm_pkg::REG_CONFIG:      read_sel = cfg;
      stm_pkg::REG_SCRATCH:     read_sel = scr;
      stm_pkg::REG_TEMP_LOCAL:  read_sel = loc;
      stm_pkg::REG_TEMP_REMOTE: read_sel = rem;
      default:                  read_sel = stm_pkg::UNMAPPED_READ;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Averaged remote conversion
  stm_conv #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .sample     (remote_sample),
    .result_reg (remote_temp),
    .result_new (result_new)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; only the second stage feeds any logic
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // Edge and condition detection
  always_comb
  begin
    ev.sda      = sda_sync_reg[1];
    ev.scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
    ev.scl_fall = ~scl_sync_reg[1] & scl_prev_reg;
    ev.start    = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
    ev.stop     = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte sequencer: receive, acknowledge, transmit, master acknowledge
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_reg    <= stm_pkg::ST_IDLE;
      bit_reg      <= stm_pkg::BIT_FIRST;
      shift_reg    <= 8'h00;
      wbyte_reg    <= stm_pkg::WR_ADDR;
      dir_rd_reg   <= 1'b0;
      addr_hit_reg <= 1'b0;
    end
    else if (ev.stop)
      state_reg <= stm_pkg::ST_IDLE;
    else if (ev.start)
    begin
      // A repeated START also lands here; direction is re-taken from the address
      state_reg  <= stm_pkg::ST_RECV;
      bit_reg    <= stm_pkg::BIT_FIRST;
      wbyte_reg  <= stm_pkg::WR_ADDR;
      dir_rd_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        stm_pkg::ST_IDLE:
          state_reg <= stm_pkg::ST_IDLE;
        stm_pkg::ST_RECV:
          if (ev.scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], ev.sda};
            bit_reg   <= bit_reg + 4'h1;
          end
          else if (ev.scl_fall && bit_reg == stm_pkg::BIT_ACK)
          begin
            bit_reg <= stm_pkg::BIT_FIRST;
            if (wbyte_reg == stm_pkg::WR_ADDR)
            begin
              addr_hit_reg <= (shift_reg[7:1] == stm_pkg::DEV_ADDR_RESET);
              dir_rd_reg   <= shift_reg[0];
              state_reg    <= (shift_reg[7:1] == stm_pkg::DEV_ADDR_RESET)
                              ? stm_pkg::ST_ACK : stm_pkg::ST_IDLE;
            end
            else
              state_reg <= (wbyte_reg == stm_pkg::WR_OVER)
                           ? stm_pkg::ST_IDLE : stm_pkg::ST_ACK;
          end
        stm_pkg::ST_ACK:
          if (ev.scl_fall)
          begin
            // Ninth pulse done; next byte goes out or comes in
            state_reg <= dir_rd_reg ? stm_pkg::ST_SEND : stm_pkg::ST_RECV;
            wbyte_reg <= (wbyte_reg == stm_pkg::WR_OVER) ? wbyte_reg : wbyte_reg + 2'h1;
          end
        stm_pkg::ST_SEND:
          if (ev.scl_fall)
          begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == stm_pkg::BIT_LAST)
              state_reg <= stm_pkg::ST_MACK;
          end
        stm_pkg::ST_MACK:
          if (ev.scl_fall)
          begin
            // Single-byte reads: any answer ends the data phase
            bit_reg   <= stm_pkg::BIT_FIRST;
            state_reg <= stm_pkg::ST_IDLE;
          end
        default:
          state_reg <= stm_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode: pointer on the first byte, register data on the second
  always_comb
  begin
    wr.valid = (state_reg == stm_pkg::ST_RECV) && ev.scl_fall && !ev.start && !ev.stop
               && bit_reg == stm_pkg::BIT_ACK && !dir_rd_reg;
    wr.index = ptr_reg;
    wr.data  = shift_reg;
  end

  // Pointer survives STOP so a bare read reuses it
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ptr_reg <= stm_pkg::PTR_RESET;
    else if (wr.valid && wbyte_reg == stm_pkg::WR_PTR)
      ptr_reg <= wr.data;
  end

  // Writable registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      config_reg  <= stm_pkg::CONFIG_RESET;
      scratch_reg <= stm_pkg::SCRATCH_RESET;
    end
    else if (wr.valid && wbyte_reg == stm_pkg::WR_DATA)
    begin
      if (wr.index == stm_pkg::REG_CONFIG)
        config_reg <= wr.data;
      if (wr.index == stm_pkg::REG_SCRATCH)
        scratch_reg <= wr.data;
    end
  end

  // Local temperature is latched at each remote result so both read coherently
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      local_reg <= stm_pkg::TEMP_RESET;
    else if (result_new)
      local_reg <= local_temp;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Selected byte, shared so the first driven bit and the shifter cannot disagree
  assign rd_byte = read_sel(ptr_reg, config_reg, scratch_reg, local_reg, remote_temp);

  // Transmit shifter loaded when the read address is acknowledged
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tx_reg <= 8'h00;
    else if (state_reg == stm_pkg::ST_ACK && ev.scl_fall && dir_rd_reg)
      tx_reg <= rd_byte;
    else if (state_reg == stm_pkg::ST_SEND && ev.scl_fall)
      tx_reg <= {tx_reg[6:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Open-drain driver: only ever pulls low, changes only while SCL is low
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      drive_low_reg <= 1'b0;
    else if (ev.stop || ev.start)
      drive_low_reg <= 1'b0;
    else if (ev.scl_fall)
    begin
      if (state_reg == stm_pkg::ST_RECV && bit_reg == stm_pkg::BIT_ACK)
        drive_low_reg <= addr_hit_reg || wbyte_reg != stm_pkg::WR_ADDR
                         ? (wbyte_reg != stm_pkg::WR_OVER &&
                            (wbyte_reg != stm_pkg::WR_ADDR ||
                             shift_reg[7:1] == stm_pkg::DEV_ADDR_RESET))
                         : (shift_reg[7:1] == stm_pkg::DEV_ADDR_RESET);
      else if (state_reg == stm_pkg::ST_ACK && dir_rd_reg)
        drive_low_reg <= ~rd_byte[7];
      else if (state_reg == stm_pkg::ST_SEND && bit_reg != stm_pkg::BIT_LAST)
        drive_low_reg <= ~tx_reg[6];
      else
        drive_low_reg <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_reg;
  assign busy    = (state_reg != stm_pkg::ST_IDLE);

endmodule
`default_nettype wire

// ### hw/stm_pkg.sv
// Shared constants and carrier types for the temperature monitor serial slave
package stm_pkg;

  // Bus address loaded at power-up (7 bits, binary 0101110)
  localparam logic [6:0] DEV_ADDR_RESET = 7'h2e;

  // Register pointer value after reset
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Internal register indices reachable through the pointer
  localparam logic [7:0] REG_CONFIG      = 8'h40;
  localparam logic [7:0] REG_TEMP_LOCAL  = 8'h26;
  localparam logic [7:0] REG_TEMP_REMOTE = 8'h27;
  localparam logic [7:0] REG_SCRATCH     = 8'h15;

  // Reset values of the writable and temperature registers, and the unmapped read filler
  localparam logic [7:0] CONFIG_RESET  = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] TEMP_RESET    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Averaging depth for remote results and its log2
  localparam int          AVG_COUNT = 16;
  localparam int          AVG_SHIFT = 4;
  localparam logic [3:0]  AVG_LAST  = 4'hf;

  // Conversion pacing: 9.6 ms per averaged result at 200 MHz
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real CONV_TIME_MS  = 9.6;
  localparam int  CONV_CYCLES   = int'(CONV_TIME_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  SUB_CYCLES    = CONV_CYCLES / AVG_COUNT;

  // Bit counter positions inside a nine-pulse byte slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  // Byte position inside a write operation
  localparam logic [1:0] WR_ADDR = 2'h0;
  localparam logic [1:0] WR_PTR  = 2'h1;
  localparam logic [1:0] WR_DATA = 2'h2;
  localparam logic [1:0] WR_OVER = 2'h3;

  // Slave sequencer states
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK  = 5'h04,
    ST_SEND = 5'h08,
    ST_MACK = 5'h10
  } stm_state_type;

  // Sampled bus conditions on the mclk domain
  typedef struct packed
  {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } stm_bus_ev_type;

  // One register write from the serial side
  typedef struct packed
  {
    logic       valid;
    logic [7:0] index;
    logic [7:0] data;
  } stm_wr_type;

endpackage

// ### hw/stm_conv.sv
// Conversion timebase and 16-sample averager for the remote temperature result
`timescale 1ns/10ps
`default_nettype none

module stm_conv #(
  parameter int CONV_CYCLES = stm_pkg::CONV_CYCLES
)
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Raw measurement sample, two's complement degrees
  input  wire logic [7:0] sample,
  // Averaged result
  output logic [7:0]      result_reg,
  output logic            result_new
);

  localparam int SUB = (CONV_CYCLES / stm_pkg::AVG_COUNT) < 1 ? 1
                     : (CONV_CYCLES / stm_pkg::AVG_COUNT);

  logic [31:0] tick_reg;
  logic [3:0]  cnt_reg;
  logic [11:0] acc_reg;
  logic        sub_tick;
  logic [11:0] acc_sum;

  assign sub_tick = (tick_reg == 32'(SUB - 1));
  assign acc_sum  = acc_reg + {{4{sample[7]}}, sample};

  ////////////////////////////////////////////////////////////////////////////////
  // Sub-measurement pacing, sixteen per result gives the full conversion time
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tick_reg <= 32'h0;
    else if (sub_tick)
      tick_reg <= 32'h0;
    else
      tick_reg <= tick_reg + 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sign-extended accumulation; an arithmetic shift keeps two's complement
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_reg    <= 4'h0;
      acc_reg    <= 12'h0;
      result_reg <= stm_pkg::TEMP_RESET;
      result_new <= 1'b0;
    end
    else
    begin
      result_new <= 1'b0;
      if (sub_tick)
      begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == stm_pkg::AVG_LAST)
        begin
          acc_reg    <= 12'h0;
          result_reg <= acc_sum[11:4];
          result_new <= 1'b1;
        end
        else
          acc_reg <= acc_sum;
      end
    end
  end

endmodule
`default_nettype wire

// ### tb/stm_slave_monitor.sv
// Concurrent checks on the serial slave pins and register outputs
`timescale 1ns/10ps
`default_nettype none

module stm_slave_monitor #(
  parameter int CONV_CYCLES = stm_pkg::CONV_CYCLES
)
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Serial pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Register side
  input wire logic [7:0] config_reg,
  input wire logic [7:0] scratch_reg,
  input wire logic       busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Pin behaviour: the data pin is only ever pulled low, and its drive changes only while SCL is low
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  oe_high_stable_a: assert property ($rose(scl_in) |=> $stable(sda_oe) [*8])
    else $error("data drive moved inside clock high phase");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("low drive too short");
  oe_busy_a: assert property (sda_oe |-> busy)
    else $error("drive while idle");

  ////////////////////////////////////////////////////////////////////////////////////////
  // Framing: raw pins are asynchronous, so allow the synchroniser delay
  start_busy_a: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:8] busy)
    else $error("start not taken");
  stop_idle_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:8] !busy)
    else $error("stop did not return to idle");
  cfg_quiet_a: assert property ($changed(config_reg) |-> busy)
    else $error("config changed outside a transfer");
  scr_quiet_a: assert property ($changed(scratch_reg) |-> busy)
    else $error("scratch changed outside a transfer");

  // Main scenarios reached
  ack_seen_c: cover property ($rose(sda_oe));
  wr_seen_c: cover property ($changed(scratch_reg));
  stop_seen_c: cover property (scl_in && $rose(sda_in) ##[1:8] !busy);
endmodule

bind stm_slave stm_slave_monitor #(.CONV_CYCLES(CONV_CYCLES)) stm_slave_monitor_i (
  .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .config_reg(config_reg), .scratch_reg(scratch_reg), .busy(busy));

`default_nettype wire

// ### tb/stm_master_model.sv
// Behavioural bus master on the far side of the serial slave
`timescale 1ns/10ps
`default_nettype none

module stm_master_model
(
  // Wired bus
  output logic      scl_o,
  output logic      sda_rel,
  input  wire logic sda_line
);
  localparam real QTR = 31.25;  // Quarter of the 125 ns link period

  // Bus rests released; the pull-up holds both lines high
  initial
  begin
    scl_o = 1'b1;
    sda_rel = 1'b1;
  end

  // One clock pulse; data moves mid low phase so it never changes while SCL is high
  task automatic bus_bit(input logic b, output logic s);
    sda_rel = b;
    #QTR;
    scl_o = 1'b1;
    #QTR;
    s = sda_line;
    #QTR;
    scl_o = 1'b0;
    #QTR;
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic bus_start();
    sda_rel = 1'b1;
    #QTR;
    scl_o = 1'b1;
    #(2*QTR);
    sda_rel = 1'b0;
    #(2*QTR);
    scl_o = 1'b0;
    #QTR;
  endtask

  // Stop: data pulled low, then raised while clock is high
  task automatic bus_stop();
    sda_rel = 1'b0;
    #QTR;
    scl_o = 1'b1;
    #(2*QTR);
    sda_rel = 1'b1;
    #(2*QTR);
  endtask

  // Eight bits out, most significant first, then the receiver's acknowledge slot
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--)
      bus_bit(d[i], s);
    bus_bit(1'b1, ack_n);
  endtask

  // Eight bits in, then our own acknowledge or refusal
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bus_bit(1'b1, s);
      d[i] = s;
    end
    bus_bit(nack, s);
  endtask
endmodule

`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the serial slave front end
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int CONV = 160;                 // Short conversion keeps the run brief
  localparam logic [6:0] ADDR = 7'h2e;
  logic       mclk;
  logic       rst_n;
  logic       scl_w;
  logic       sda_rel;
  logic       sda_w;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] local_temp;
  logic [7:0] remote_sample;
  logic [7:0] config_reg;
  logic [7:0] scratch_reg;
  logic [7:0] remote_temp;
  logic       busy;
  int         error_cnt;
  int         num_checks;

  // Open-drain data line with pull-up: any low drive wins
  assign sda_w = sda_oe ? (sda_out & sda_rel) : sda_rel;

  // Design and far-side master
  stm_slave #(.CONV_CYCLES(CONV)) stm_slave_i (.mclk(mclk), .rst_n(rst_n), .scl_in(scl_w),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .local_temp(local_temp),
    .remote_sample(remote_sample), .config_reg(config_reg), .scratch_reg(scratch_reg),
    .remote_temp(remote_temp), .busy(busy));
  stm_master_model stm_master_model_i (.scl_o(scl_w), .sda_rel(sda_rel), .sda_line(sda_w));

  always #2.5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Bus operations; na collects the acknowledge bits, 1 meaning refused
  task automatic wr_op(input logic [6:0] a, input logic [7:0] q[$], output logic [3:0] na);
    logic k;
    na = 4'h0;
    stm_master_model_i.bus_start();
    stm_master_model_i.put_byte({a, 1'b0}, k);
    na[0] = k;
    foreach (q[i])
    begin
      stm_master_model_i.put_byte(q[i], k);
      na[i+1] = k;
    end
    stm_master_model_i.bus_stop();
  endtask

  task automatic rd_op(input logic sp, input logic [7:0] p, output logic [7:0] d,
                       output logic [2:0] na);
    logic k;
    na = 3'h0;
    stm_master_model_i.bus_start();
    if (sp)
    begin
      stm_master_model_i.put_byte({ADDR, 1'b0}, k);
      na[0] = k;
      stm_master_model_i.put_byte(p, k);
      na[1] = k;
      stm_master_model_i.bus_start();
    end
    stm_master_model_i.put_byte({ADDR, 1'b1}, k);
    na[2] = k;
    stm_master_model_i.get_byte(1'b1, d);
    stm_master_model_i.bus_stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check(8'({busy, sda_oe, sda_out}), 8'h00);
    check(config_reg, 8'h00);
    check(scratch_reg, 8'h00);
  endtask

  task automatic t_write();
    logic [3:0] na;
    wr_op(ADDR, '{stm_pkg::REG_SCRATCH, 8'ha5}, na);
    check(8'(na), 8'h00);
    check(scratch_reg, 8'ha5);
  endtask

  task automatic t_extra();
    logic [3:0] na;
    wr_op(ADDR, '{stm_pkg::REG_SCRATCH, 8'h11, 8'h22}, na);
    check(8'(na), 8'h08);
    check(scratch_reg, 8'h11);
  endtask

  task automatic t_read();
    logic [3:0] na;
    logic [2:0] nr;
    logic [7:0] d;
    wr_op(ADDR, '{stm_pkg::REG_CONFIG, 8'h3c}, na);
    check(config_reg, 8'h3c);
    rd_op(1'b1, stm_pkg::REG_CONFIG, d, nr);
    check(8'(nr), 8'h00);
    check(d, 8'h3c);
    // An index with no register behind it still answers, with the fixed filler
    rd_op(1'b1, 8'h01, d, nr);
    check(8'(nr), 8'h00);
    check(d, stm_pkg::UNMAPPED_READ);
  endtask

  task automatic t_ptr_hold();
    logic [3:0] na;
    logic [2:0] nr;
    logic [7:0] d;
    wr_op(ADDR, '{stm_pkg::REG_SCRATCH}, na);
    check(config_reg, 8'h3c);
    rd_op(1'b0, 8'h00, d, nr);
    check(8'(nr), 8'h00);
    check(d, 8'h11);
  endtask

  // Near misses: one bit off, bit order reversed, shifted; data mimics the own address
  task automatic t_foreign();
    logic [6:0] bad[3] = '{7'h2f, 7'h3a, 7'h17};
    logic [3:0] na;
    foreach (bad[i])
    begin
      wr_op(bad[i], '{8'h5c, 8'h77}, na);
      check(8'(na), 8'h07);
      check(scratch_reg, 8'h11);
    end
  endtask

  task automatic t_temp();
    logic [7:0] tv[5] = '{8'h64, 8'hff, 8'h9c, 8'h80, 8'h7f};
    logic [2:0] nr;
    logic [7:0] d;
    foreach (tv[i])
    begin
      @(posedge mclk);
      #1;
      remote_sample = tv[i];
      local_temp = tv[i];
      repeat (140) @(posedge mclk);
      #1;
      check(8'(remote_temp === tv[i]), 8'h00);
      repeat (200) @(posedge mclk);
      #1;
      check(remote_temp, tv[i]);
      rd_op(1'b1, stm_pkg::REG_TEMP_REMOTE, d, nr);
      check(d, tv[i]);
      rd_op(1'b1, stm_pkg::REG_TEMP_LOCAL, d, nr);
      check(d, tv[i]);
    end
  endtask

  // Two samples alternate, one per 10-cycle sub-period, so each result sums eight of
  // each: +100 and -101 average to -1 after the floor; keeping one sample would not
  task automatic t_average();
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      #1;
      remote_sample = n[0] ? 8'h9b : 8'h64;
      repeat (9) @(posedge mclk);
    end
    #1;
    check(remote_temp, 8'hff);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    local_temp = 8'h00;
    remote_sample = 8'h00;
    error_cnt = 0;
    num_checks = 0;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    t_reset();
    t_write();
    t_extra();
    t_read();
    t_ptr_hold();
    t_foreign();
    t_temp();
    t_average();
    final_report();
  end

  // Watchdog well beyond the expected run of about 20k cycles
  initial
  begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule

`default_nettype wire
